// ===== logic/irq_pins_init_status.sv
// Interrupt pin front end and init status output of the processor.
// Assumes the memory checksum read path and acknowledge cycle sequencer are outside.
`timescale 1ns/1ps
module irq_pins_init_status (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration from bus interrupt control
  input wire irq_pins_pkg::irq_cfg_s cfg,
  // Interrupt pins, active low
  input wire logic irq_line_zero_n,
  input wire logic irq_line_one_n,
  input wire logic irq_line_two_n,
  input wire logic irq_line_three_in_n,
  output logic irq_line_three_out,
  output logic irq_line_three_oe,
  // Strap and init status
  input wire logic bad_access_in,
  output logic init_fail_out,
  output logic init_fail_oe,
  output logic self_init_strap,
  output logic reserved_strap_seen,
  // Self-test and checksum handshake
  input wire logic self_test_ok,
  output logic sum_read_req,
  input wire logic sum_word_valid,
  input wire logic [31:0] sum_word,
  output logic init_done,
  // Interrupt-acknowledge transaction
  input wire logic ack_start,
  input wire logic data_cycle,
  input wire logic ack_end,
  output logic lock_out,
  // Qualified events
  output irq_pins_pkg::irq_events_s events
);
  import irq_pins_pkg::*;

  init_state_e state;
  init_state_e next_state;
  logic [3:0] div_cnt;
  logic [7:0] test_cnt;
  logic [3:0] word_cnt;
  logic [31:0] sum;
  logic in_ack;
  logic ack_latched;
  wire logic [3:0] hits;

  wire logic bus_tick = (div_cnt == bus_cycle_last);
  wire logic [31:0] next_sum = sum + sum_word;
  wire logic last_word = (word_cnt == sum_words - 4'h1);
  wire logic [1:0] need = need_count(cfg.async_mode);
  // only line zero and bad access matter under reset
  wire logic sample = bus_tick && !reset;
  wire logic [3:0] lines_n = {irq_line_three_in_n, irq_line_two_n, irq_line_one_n, irq_line_zero_n};
  wire logic ack_go = ack_start && cfg.line_three_is_ack;

  always_ff @(posedge clk) begin
    if (reset) div_cnt <= 4'h0;
    else div_cnt <= bus_tick ? 4'h0 : div_cnt + 4'h1;
  end

  for (genvar i = 0; i < irq_lines; i++) begin : g_line
    irq_edge_qualifier u_q (
      .clk(clk),
      .reset(reset),
      .sample(sample),
      .line_n(lines_n[i]),
      .need(need),
      .hit(hits[i])
    );
  end

  // straps caught while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      self_init_strap <= bad_access_in;
      // low line zero during reset is reserved
      reserved_strap_seen <= !irq_line_zero_n;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      st_reset: next_state = st_self_test;
      st_self_test: if (bus_tick && test_cnt == self_test_cycles) begin
        next_state = self_test_ok ? st_sum_req : st_failed;
      end
      st_sum_req: next_state = st_sum_wait;
      st_sum_wait: if (sum_word_valid && last_word) begin
        next_state = (next_sum == 32'h0) ? st_run : st_failed;
      end
      st_run: next_state = st_run;
      st_failed: next_state = st_failed;
      default: next_state = st_reset;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_reset;
      test_cnt <= 8'h0;
      word_cnt <= 4'h0;
      sum <= 32'h0;
    end else begin
      state <= next_state;
      if (state == st_self_test && bus_tick) test_cnt <= test_cnt + 8'h1;
      if (state == st_sum_wait && sum_word_valid) begin
        sum <= next_sum;
        word_cnt <= word_cnt + 4'h1;
      end
    end
  end

  // Open-drain: pulled low during self-test and once failed
  always_ff @(posedge clk) begin
    if (reset) begin
      init_fail_out <= 1'b0;
      init_fail_oe <= 1'b0;
      sum_read_req <= 1'b0;
      init_done <= 1'b0;
    end else begin
      init_fail_oe <= (next_state == st_self_test) || (next_state == st_failed);
      init_fail_out <= 1'b0;
      sum_read_req <= (next_state == st_sum_req);
      init_done <= (next_state == st_run);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      events <= '0;
    end else begin
      events.message <= hits[0] && cfg.line_zero_is_message;
      events.irq[0] <= hits[0] && !cfg.line_zero_is_message;
      events.irq[1] <= hits[1];
      events.ext_req <= hits[2] && cfg.line_two_is_ext_ctrl;
      events.irq[2] <= hits[2] && !cfg.line_two_is_ext_ctrl;
      events.irq[3] <= hits[3] && !cfg.line_three_is_ack;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      in_ack <= 1'b0;
      ack_latched <= 1'b0;
      lock_out <= 1'b0;
      irq_line_three_out <= 1'b0;
      irq_line_three_oe <= 1'b0;
    end else begin
      if (ack_go) begin
        in_ack <= 1'b1;
        ack_latched <= 1'b1;
      end else if (ack_end) begin
        in_ack <= 1'b0;
        if (!data_cycle) ack_latched <= 1'b0;
      end else if (!in_ack && !data_cycle) begin
        ack_latched <= 1'b0;
      end
      lock_out <= ack_go || (in_ack && !ack_end);
      irq_line_three_out <= 1'b0;
      irq_line_three_oe <= cfg.line_three_is_ack && (ack_go || (ack_latched && !ack_end));
    end
  end

  a_fail_in_test: assert property (@(posedge clk) disable iff (reset)
    (state == st_self_test) |-> init_fail_oe) else $error("fail not driven in self-test");
  a_fail_sticks: assert property (@(posedge clk) disable iff (reset)
    (state == st_failed) |=> init_fail_oe && state == st_failed) else $error("init_fail_out released");
  a_run_quiet: assert property (@(posedge clk) disable iff (reset)
    (state == st_run) |=> !init_fail_oe) else $error("fail driven in run");
  a_msg_route: assert property (@(posedge clk) disable iff (reset)
    events.message |-> $past(cfg.line_zero_is_message)) else $error("message misrouted");
  a_line_one: assert property (@(posedge clk) disable iff (reset)
    hits[1] |=> events.irq[1]) else $error("line one lost");
  a_ext_route: assert property (@(posedge clk) disable iff (reset)
    hits[2] |=> events.ext_req != events.irq[2]) else $error("line two lost or doubled");
  a_ack_no_irq: assert property (@(posedge clk) disable iff (reset)
    hits[3] |=> events.irq[3] == !$past(cfg.line_three_is_ack)) else $error("line three misrouted");
  a_ack_od: assert property (@(posedge clk) disable iff (reset)
    irq_line_three_oe |-> !irq_line_three_out) else $error("ack drives high");
  a_lock_ack: assert property (@(posedge clk) disable iff (reset)
    (in_ack && !ack_end) |=> lock_out) else $error("lock dropped in ack");
  a_lock_start: assert property (@(posedge clk) disable iff (reset)
    ack_go |=> lock_out && irq_line_three_oe) else $error("lock or acknowledge late");
  a_ack_idle: assert property (@(posedge clk) disable iff (reset)
    !cfg.line_three_is_ack |=> !irq_line_three_oe) else $error("acknowledge driven as input");
  a_ack_hold: assert property (@(posedge clk) disable iff (reset)
    irq_line_three_oe && data_cycle && !ack_end |=> irq_line_three_oe) else $error("acknowledge dropped");
  // Checked without disable, since reset itself is the antecedent
  a_reset_quiet: assert property (@(posedge clk)
    reset |=> events == '0 && hits == 4'h0 && !lock_out) else $error("activity under reset");

  // Init steps: self-test hand-over, then the checksum verdict
  sequence s_test_pass;
    state == st_self_test ##1 state == st_sum_req;
  endsequence
  sequence s_sum_last;
    state == st_sum_wait && sum_word_valid && last_word;
  endsequence
  a_sum_start: assert property (@(posedge clk) disable iff (reset)
    s_test_pass |-> sum_read_req ##1 !sum_read_req && !init_fail_oe) else $error("checksum not started");
  a_sum_bad: assert property (@(posedge clk) disable iff (reset)
    s_sum_last ##0 (next_sum != 32'h0) |=> state == st_failed && init_fail_oe)
    else $error("bad checksum accepted");
  a_sum_good: assert property (@(posedge clk) disable iff (reset)
    s_sum_last ##0 (next_sum == 32'h0) |=> state == st_run && init_done && !init_fail_oe)
    else $error("good checksum refused");
endmodule : irq_pins_init_status

// ===== logic/irq_pins_pkg.sv
// Package for the interrupt pin front end: init status states, config, timing.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package irq_pins_pkg;

  localparam int unsigned clk_period_ns = 5;
  // Bus cycle length in ns; each bus cycle is several core clocks
  localparam int unsigned bus_cycle_ns = 40;
  localparam int unsigned bus_cycle_clks = (bus_cycle_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] bus_cycle_last = 4'(bus_cycle_clks - 1);
  // Self-test length in bus cycles
  localparam logic [7:0] self_test_cycles = 8'h20;
  // Words summed by the zero check
  localparam logic [3:0] sum_words = 4'h8;
  // Sync and async required sample counts
  localparam logic [1:0] sync_need = 2'h1;
  localparam logic [1:0] async_need = 2'h2;
  localparam int unsigned irq_lines = 4;

  typedef enum logic [2:0] {
    st_reset, st_self_test, st_sum_req, st_sum_wait, st_run, st_failed
  } init_state_e;

  // Bus interrupt control configuration
  typedef struct packed {
    logic line_zero_is_message;
    logic line_two_is_ext_ctrl;
    logic line_three_is_ack;
    logic async_mode;
  } irq_cfg_s;

  typedef struct packed {
    logic [3:0] irq;
    logic message;
    logic ext_req;
  } irq_events_s;

  function automatic logic [1:0] need_count(input logic async_mode);
    return async_mode ? async_need : sync_need;
  endfunction : need_count

endpackage : irq_pins_pkg

// ===== logic/irq_edge_qualifier.sv
// One interrupt line qualifier: inactive-then-active on bus-cycle samples.
// Assumes sample strobe is one clock per bus cycle; lines are active low.
`timescale 1ns/1ps
module irq_edge_qualifier (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sampling
  input wire logic sample,
  input wire logic line_n,
  input wire logic [1:0] need,
  // Result
  output logic hit
);
  import irq_pins_pkg::*;

  logic [1:0] high_cnt;
  logic [1:0] low_cnt;
  logic armed;
  wire logic high_done = high_cnt >= need;
  wire logic low_done = (low_cnt + 2'h1) >= need;

  always_ff @(posedge clk) begin
    if (reset) begin
      high_cnt <= 2'h0;
      low_cnt <= 2'h0;
      armed <= 1'b0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (sample) begin
        if (line_n) begin
          low_cnt <= 2'h0;
          if (!high_done) high_cnt <= high_cnt + 2'h1;
          armed <= high_done || ((high_cnt + 2'h1) >= need);
        end else begin
          high_cnt <= 2'h0;
          if (armed && low_done) begin
            hit <= 1'b1;
            armed <= 1'b0;
            low_cnt <= 2'h0;
          end else if (armed) begin
            low_cnt <= low_cnt + 2'h1;
          end
        end
      end
    end
  end

  a_hit_needs_sample: assert property (@(posedge clk) disable iff (reset)
    hit |-> $past(sample) && !$past(line_n)) else $error("hit without low sample");
endmodule : irq_edge_qualifier

// ===== verification/irq_source_model.sv
// Source model for the four active-low interrupt lines.
// Assumes bus cycle length from the package; idle lines sit high on their pull-ups.
`timescale 1ns/1ps
module irq_source_model (
  // Clock
  input wire logic clk,
  // Strap control
  input wire logic reserved_low,
  // Lines, active low
  output logic [3:0] lines_n
);
  import irq_pins_pkg::*;
  logic [3:0] drv_n = 4'hf;
  assign lines_n = {drv_n[3:1], drv_n[0] & ~reserved_low};
  task automatic pulse(input int line, input int span);
    repeat (span * bus_cycle_clks) @(posedge clk);
    #1 drv_n[line] = 1'b0;
    repeat (span * bus_cycle_clks) @(posedge clk);
    #1 drv_n[line] = 1'b1;
  endtask : pulse
endmodule : irq_source_model

// ===== verification/irq_pins_init_status_tb.sv
// Bench for the interrupt pin front end: init status, qualifiers, acknowledge.
// Assumes the source model drives the pins; this bench plays memory and sequencer.
`timescale 1ns/1ps
module irq_pins_init_status_tb;
  import irq_pins_pkg::*;
  logic clk = 0, reset = 1, bad_access_in = 0, self_test_ok = 0, sum_word_valid = 0;
  logic ack_start = 0, data_cycle = 0, ack_end = 0, reserved_low = 1;
  logic [31:0] sum_word = 32'h0;
  irq_cfg_s cfg = '0;
  logic [3:0] lines_n;
  logic line_three_out, line_three_oe, fail_out, fail_oe, strap, res_seen, sum_req, done, lock;
  irq_events_s events;
  logic [5:0] exp_q[$];
  logic [5:0] ev;
  int n_errors = 0, cmp_count = 0;
  // Open-drain wire: either party pulls it low
  wire line_three_n = lines_n[3] & ~line_three_oe;
  initial forever #2.5 clk = ~clk;
  irq_source_model i_irq_source_model (.clk(clk), .reserved_low(reserved_low), .lines_n(lines_n));
  irq_pins_init_status i_irq_pins_init_status (.clk(clk), .reset(reset), .cfg(cfg),
    .irq_line_zero_n(lines_n[0]), .irq_line_one_n(lines_n[1]), .irq_line_two_n(lines_n[2]),
    .irq_line_three_in_n(line_three_n), .irq_line_three_out(line_three_out),
    .irq_line_three_oe(line_three_oe), .bad_access_in(bad_access_in), .init_fail_out(fail_out),
    .init_fail_oe(fail_oe), .self_init_strap(strap), .reserved_strap_seen(res_seen),
    .self_test_ok(self_test_ok), .sum_read_req(sum_req), .sum_word_valid(sum_word_valid),
    .sum_word(sum_word), .init_done(done), .ack_start(ack_start), .data_cycle(data_cycle),
    .ack_end(ack_end), .lock_out(lock), .events(events));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  function automatic logic [5:0] exp_ev(input int k, input irq_cfg_s c);
    if (k == 0 && c.line_zero_is_message) return 6'h02;
    if (k == 2 && c.line_two_is_ext_ctrl) return 6'h01;
    if (k == 3 && c.line_three_is_ack) return 6'h00;
    return 6'(1 << (k + 2));
  endfunction : exp_ev
  // Oldest note is compared against each event pulse
  always @(posedge clk) begin
    if (!reset && events !== 6'h00) begin
      if (exp_q.size() == 0)
        check(events, 6'h00);
      else
        check(events, exp_q.pop_front());
    end
  end
  task automatic do_reset(input irq_cfg_s c, input logic s, input int len);
    @(posedge clk);
    #1 reset = 1;
    cfg = c;
    bad_access_in = s;
    repeat (len) @(posedge clk);
    #1 reset = 0;
    bad_access_in = 0;
    reserved_low = 0;
  endtask : do_reset
  task automatic run_init(input logic ok, input logic bad);
    logic [31:0] acc;
    logic [31:0] w;
    int n;
    acc = 32'h0;
    n = 0;
    self_test_ok = ok;
    repeat (2) @(posedge clk);
    #2 check({fail_oe, fail_out}, 2'b10);
    while (sum_req !== 1'b1 && n < 400) begin
      if (n < 250) check(fail_oe, 1'b1);
      @(posedge clk);
      #2 n++;
    end
    check(n < 400, ok);
    check(fail_oe, !ok);
    for (int i = 0; i < 8 && ok; i++) begin
      w = (i == 7) ? 32'h0 - acc + {31'h0, bad} : $urandom;
      acc = acc + w;
      @(posedge clk);
      #1 sum_word_valid = 1;
      sum_word = w;
    end
    @(posedge clk);
    #1 sum_word_valid = 0;
    repeat (40) @(posedge clk);
    #2 check({fail_oe, done, fail_out}, {!(ok && !bad), ok && !bad, 1'b0});
  endtask : run_init
  task automatic ack_cycle();
    @(posedge clk);
    #1 ack_start = 1;
    @(posedge clk);
    #1 ack_start = 0;
    data_cycle = 1;
    repeat (3) begin
      @(posedge clk);
      #1 check(lock, 1'b1);
      check({line_three_oe, line_three_out}, 2'b10);
    end
    @(posedge clk);
    #1 data_cycle = 0;
    ack_end = 1;
    @(posedge clk);
    #1 ack_end = 0;
    repeat (2) @(posedge clk);
    #2 check(lock, 1'b0);
    check(line_three_oe, 1'b0);
  endtask : ack_cycle
  initial begin
    void'($urandom(32'h030a9734));
    repeat (3) @(posedge clk);
    #1 reset = 0;
    // Line one toggles inside a long reset and must be ignored
    fork
      do_reset(irq_cfg_s'(4'h0), 1'b1, 24);
      i_irq_source_model.pulse(1, 1);
    join
    @(posedge clk);
    #1 check(strap, 1'b1);
    check(res_seen, 1'b1);
    run_init(1'b0, 1'b0);
    $display("test straps and self-test init_fail_out done");
    do_reset(irq_cfg_s'(4'h0), 1'b0, 3);
    check(strap, 1'b0);
    check(res_seen, 1'b0);
    run_init(1'b1, 1'b1);
    $display("test bad checksum done");
    for (int c = 0; c < 16; c++) begin
      do_reset(irq_cfg_s'(c[3:0]), 1'b0, 3);
      run_init(1'b1, 1'b0);
      // Fifth pass is a one-cycle pulse on line zero, too short in async mode
      for (int k = 0; k < 5; k++) begin
        ev = (k == 4 && cfg.async_mode) ? 6'h00 : exp_ev(k % 4, cfg);
        if (ev !== 6'h00)
          exp_q.push_back(ev);
        i_irq_source_model.pulse(k % 4, (cfg.async_mode && k < 4) ? 2 : 1);
        repeat (4) @(posedge clk);
        #2 check(exp_q.size(), 0);
      end
      if (cfg.line_three_is_ack)
        ack_cycle();
      $display("test cfg %h done", cfg);
    end
    end_of_test();
  end
  initial begin
    #(40000 * clk_period_ns);
    n_errors++;
    end_of_test();
  end
endmodule : irq_pins_init_status_tb
